// ==== verilog/mdu_pkg.sv ====
// Constants, types and helpers shared by the message digest unit.
// Operation
// - Software reset bit aborts hashing at once.
// - Software reset restores every register and buffer.
// - Global enable gates the interrupt output.
// - Start bit hashes buffer, continuing running digest.
// - Block written during hashing continues automatically.
// - Byte-swap bit reverses digest bytes on read.
// - Single-round bit advances one round per step.
// - Completion sets done and, if enabled, interrupt on the same edge.
// - Status bits: pending 28, error 29, empty 30, done 31.
// - Buffer copy into engine sets buffer-empty.
// - Buffer-empty interrupts need both enables set.
// - Unmapped selected address sets address-error flag.
// - Any status write clears it, never loads.
// - Buffer kept after hashing; host writes padding.
// - Engine owns its copy; host refills on empty.
// - Pad bits XOR written words with pad constant.
// - Outer pad copies digest, pads two-block message.
// - Digest holds cumulative hash since reset.
// - Fifth digest word meaningless for 128-bit algorithms.
// - Bit 24 MD5, bit 25 MD4, else SHA-1.
// - Dynamic bits self-clear; unused bits read zero.
// - Auto-start bit starts once buffer fully written.
package mdu_pkg;
   // Byte addresses of the registers.
   localparam logic [11:0] ADDR_MSG_LAST = 12'h03C;
   localparam logic [11:0] ADDR_DIGEST_A = 12'h040;
   localparam logic [11:0] ADDR_DIGEST_E = 12'h050;
   localparam logic [11:0] ADDR_CTRL = 12'h054;
   localparam logic [11:0] ADDR_STATUS = 12'h058;
   localparam logic [11:0] ADDR_CLR_IRQ = 12'h05C;
   localparam logic [11:0] ADDR_ID = 12'h060;
   // Control bit positions.
   localparam int CTL_BIE = 19;
   localparam int CTL_AUTO = 20;
   localparam int CTL_OPAD = 21;
   localparam int CTL_IPAD = 22;
   localparam int CTL_MD5 = 24;
   localparam int CTL_MD4 = 25;
   localparam int CTL_SRST = 26;
   localparam int CTL_IE = 27;
   localparam int CTL_GO = 28;
   localparam int CTL_SWAP = 29;
   localparam int CTL_STEP = 30;
   localparam logic [31:0] CTL_STATIC_MASK = 32'h6B78_0000;
   localparam logic [31:0] CTL_RESET = 32'h0000_0000;
   // Status bit positions.
   localparam int ST_IRQ = 28;
   localparam int ST_AE = 29;
   localparam int ST_BE = 30;
   localparam int ST_DONE = 31;
   // Identification value; arbitrary.
   localparam logic [31:0] UNIT_ID = 32'h0000_00A5;
   // Pad constants and start values.
   localparam logic [31:0] PAD_INNER = 32'h3636_3636;
   localparam logic [31:0] PAD_OUTER = 32'h5C5C_5C5C;
   localparam logic [4:0][31:0] DIGEST_IV = {32'hC3D2_E1F0, 32'h1032_5476, 32'h98BA_DCFE,
      32'hEFCD_AB89, 32'h6745_2301};
   localparam logic [31:0] ROUND_K = 32'h5A82_7999;
   // Padding words for the outer block of a two-block message.
   localparam logic [31:0] FILL_BE = 32'h8000_0000;
   localparam logic [31:0] FILL_LE = 32'h0000_0080;
   localparam logic [31:0] LEN_SHA = 32'h0000_02A0;
   localparam logic [31:0] LEN_MD = 32'h0000_0280;
   // Round counts per algorithm, last index.
   localparam logic [6:0] LAST_SHA = 7'h4F;
   localparam logic [6:0] LAST_MD5 = 7'h3F;
   localparam logic [6:0] LAST_MD4 = 7'h2F;
   typedef enum logic [1:0] {ALG_SHA1, ALG_MD5, ALG_MD4} mdu_algo_type;
   typedef enum logic {CORE_IDLE, CORE_RUN} mdu_core_state_type;

   // Reverses the byte order of one word.
   function automatic logic [31:0] swap32(input logic [31:0] v);
      return {v[7:0], v[15:8], v[23:16], v[31:24]};
   endfunction
endpackage

// ==== verilog/mdu_core_if.sv ====
// Link between the control block and the round engine.
`timescale 1ns/100ps
interface mdu_core_if;
   logic start;
   logic clr;
   logic round_en;
   mdu_pkg::mdu_algo_type algo;
   logic [15:0][31:0] block;
   logic dg_wr;
   logic [2:0] dg_idx;
   logic [31:0] dg_wdata;
   logic [4:0][31:0] digest;
   logic busy;
   logic blk_done;
   modport core (input start, clr, round_en, algo, block, dg_wr, dg_idx, dg_wdata,
      output digest, busy, blk_done);
   modport ctl (output start, clr, round_en, algo, block, dg_wr, dg_idx, dg_wdata,
      input digest, busy, blk_done);
endinterface

// ==== verilog/mdu_round_core.sv ====
// Round engine: captures a block, runs the rounds, accumulates the digest.
`timescale 1ns/100ps
module mdu_round_core (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // Control side.
   mdu_core_if.core cif
);
   typedef struct packed {
      mdu_pkg::mdu_core_state_type state;
      logic [6:0] rnd;
      logic [15:0][31:0] w;
      logic [4:0][31:0] v;
      logic [4:0][31:0] dg;
      logic done;
   } mdu_core_st_type;
   mdu_core_st_type s_q, s_d;
   logic [31:0] f;
   logic [6:0] last;

   // One compact round per enable; the digest adds on completion.
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      f = (s_q.v[1] & s_q.v[2]) | (~s_q.v[1] & s_q.v[3]);
      unique case (cif.algo)
         mdu_pkg::ALG_MD5: last = mdu_pkg::LAST_MD5;
         mdu_pkg::ALG_MD4: last = mdu_pkg::LAST_MD4;
         default: last = mdu_pkg::LAST_SHA;
      endcase
      unique case (s_q.state)
         mdu_pkg::CORE_IDLE: begin
            if (cif.dg_wr) begin
               s_d.dg[cif.dg_idx] = cif.dg_wdata;
            end
            if (cif.start) begin
               s_d.w = cif.block;
               s_d.v = s_q.dg;
               s_d.rnd = 7'h00;
               s_d.state = mdu_pkg::CORE_RUN;
            end
         end
         mdu_pkg::CORE_RUN: begin
            if (cif.round_en) begin
               s_d.v[0] = {s_q.v[0][26:0], s_q.v[0][31:27]} + f + s_q.v[4] + s_q.w[0]
                  + mdu_pkg::ROUND_K;
               s_d.v[1] = s_q.v[0];
               s_d.v[2] = {s_q.v[1][1:0], s_q.v[1][31:2]};
               s_d.v[3] = s_q.v[2];
               s_d.v[4] = s_q.v[3];
               s_d.w = {s_q.w[0], s_q.w[15:1]};
               s_d.rnd = s_q.rnd + 7'h01;
               if (s_q.rnd == last) begin
                  for (int i = 0; i < 5; i++) begin
                     s_d.dg[i] = s_q.dg[i] + s_d.v[i];
                  end
                  s_d.done = 1'b1;
                  s_d.state = mdu_pkg::CORE_IDLE;
               end
            end
         end
      endcase
      if (cif.clr) begin
         s_d = '{mdu_pkg::CORE_IDLE, 7'h00, '0, '0, mdu_pkg::DIGEST_IV, 1'b0};
      end
   end

   // State register.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_q <= '{mdu_pkg::CORE_IDLE, 7'h00, '0, '0, mdu_pkg::DIGEST_IV, 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign cif.digest = s_q.dg;
   assign cif.busy = (s_q.state == mdu_pkg::CORE_RUN);
   assign cif.blk_done = s_q.done;
endmodule

// ==== verilog/mdu_msg_buffer.sv ====
// Sixteen-word message buffer with pad XOR and outer-pad fill.
`timescale 1ns/100ps
module mdu_msg_buffer (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clr,
   // Host writes.
   input wire logic wr,
   input wire logic [3:0] idx,
   input wire logic [31:0] wdata,
   input wire logic ipad,
   input wire logic opad,
   // Engine side.
   input wire logic take,
   input wire mdu_pkg::mdu_algo_type algo,
   input wire logic [4:0][31:0] digest,
   output logic [15:0][31:0] block,
   output logic [15:0] written
);
   typedef struct packed {
      logic [15:0][31:0] mem;
      logic [15:0] written;
   } mdu_buf_st_type;
   mdu_buf_st_type s_q, s_d;

   // A take empties the written mask, or fills it under outer pad; a host write in the same cycle is newer and wins.
   always_comb begin
      s_d = s_q;
      if (take) begin
         s_d.written = 16'h0000;
         if (opad) begin
            for (int i = 0; i < 16; i++) begin
               s_d.mem[i] = 32'h0000_0000;
            end
            for (int i = 0; i < 4; i++) begin
               s_d.mem[i] = digest[i];
            end
            if (algo == mdu_pkg::ALG_SHA1) begin
               s_d.mem[4] = digest[4];
               s_d.mem[5] = mdu_pkg::FILL_BE;
               s_d.mem[15] = mdu_pkg::LEN_SHA;
            end else begin
               s_d.mem[4] = mdu_pkg::FILL_LE;
               s_d.mem[14] = mdu_pkg::LEN_MD;
            end
            s_d.written = 16'hFFFF;
         end
      end
      if (wr) begin
         s_d.mem[idx] = wdata ^ (ipad ? mdu_pkg::PAD_INNER : 32'h0000_0000)
            ^ (opad ? mdu_pkg::PAD_OUTER : 32'h0000_0000);
         s_d.written[idx] = 1'b1;
      end
      if (clr) begin
         s_d = '0;
      end
   end

   // State register; the buffer is never cleared by a completed hash.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign block = s_q.mem;
   assign written = s_q.written;
endmodule

// ==== verilog/mdu_message_digest_unit.sv ====
// Top of the message digest unit: APB register slave and block sequencing.
`timescale 1ns/100ps
module mdu_message_digest_unit (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt output, active high.
   output logic irq
);
   // ****************************************
   // Address decode
   // ****************************************

   // Register classes seen by the decoder.
   typedef enum logic [2:0] {
      RG_MSG, RG_DIGEST, RG_CTRL, RG_STATUS, RG_CLR, RG_ID, RG_NONE
   } mdu_reg_type;

   // Classifies a byte address; used both at setup and at access.
   function automatic mdu_reg_type reg_kind(input logic [11:0] a);
      mdu_reg_type k;
      k = RG_NONE;
      if (a[1:0] != 2'b00) begin
         k = RG_NONE;
      end else if (a <= mdu_pkg::ADDR_MSG_LAST) begin
         k = RG_MSG;
      end else if (a >= mdu_pkg::ADDR_DIGEST_A && a <= mdu_pkg::ADDR_DIGEST_E) begin
         k = RG_DIGEST;
      end else if (a == mdu_pkg::ADDR_CTRL) begin
         k = RG_CTRL;
      end else if (a == mdu_pkg::ADDR_STATUS) begin
         k = RG_STATUS;
      end else if (a == mdu_pkg::ADDR_CLR_IRQ) begin
         k = RG_CLR;
      end else if (a == mdu_pkg::ADDR_ID) begin
         k = RG_ID;
      end
      return k;
   endfunction

   // ****************************************
   // State
   // ****************************************

   // Every flip-flop of this module lives in one struct.
   typedef struct packed {
      logic [31:0] ctrl;   // Static control bits only.
      logic go;            // Start request, held until the engine takes it.
      logic chain;         // A hash is in progress across blocks.
      logic done;          // Completion flag.
      logic be;            // Buffer-empty flag.
      logic ae;            // Address-error flag.
      logic [31:0] prdata; // Read data register.
      logic pready;        // Ready register.
      logic pslverr;       // Error answer register.
      logic irq;           // Interrupt output register.
   } mdu_top_st_type;

   mdu_top_st_type s_q;
   mdu_top_st_type s_d;

   // Engine link and buffer wires.
   mdu_core_if cif ();
   logic [15:0][31:0] buf_block;
   logic [15:0] buf_written;

   // Decoded request terms.
   mdu_reg_type kind;
   logic setup;
   logic wr_acc;
   logic soft_clr;
   logic ctrl_wr;
   logic msg_wr;
   logic take;
   logic full;
   logic step_pulse;
   logic irq_pend;
   mdu_pkg::mdu_algo_type algo;
   logic [2:0] dg_idx;

   // ****************************************
   // Request decode
   // ****************************************

   // Requests are decoded from the live bus; the write acts at the edge where pready is seen.
   always_comb begin
      kind = reg_kind(paddr);
      setup = psel & ~penable;
      wr_acc = psel & penable & pwrite & s_q.pready;
      ctrl_wr = wr_acc & (kind == RG_CTRL);
      msg_wr = wr_acc & (kind == RG_MSG);
      // A control write with the reset bit clears the whole unit in that same edge.
      soft_clr = ctrl_wr & pwdata[mdu_pkg::CTL_SRST];
      // In single-round mode each further control write is one clock step.
      step_pulse = ctrl_wr & s_q.ctrl[mdu_pkg::CTL_STEP];
      dg_idx = 3'(paddr[4:2] - mdu_pkg::ADDR_DIGEST_A[4:2]);
      full = &buf_written;
   end

   // ****************************************
   // Algorithm select
   // ****************************************

   // MD5 wins if both algorithm bits are set; neither means SHA-1.
   always_comb begin
      if (s_q.ctrl[mdu_pkg::CTL_MD5]) begin
         algo = mdu_pkg::ALG_MD5;
      end else if (s_q.ctrl[mdu_pkg::CTL_MD4]) begin
         algo = mdu_pkg::ALG_MD4;
      end else begin
         algo = mdu_pkg::ALG_SHA1;
      end
   end

   // ****************************************
   // Start logic
   // ****************************************

   // The engine takes a block when idle and asked: by the start bit, by auto-start on a
   // full buffer, or by a full buffer arriving while a chain of blocks is running.
   always_comb begin
      take = ~cif.busy & ~cif.blk_done & ~soft_clr & (s_q.go
         | (s_q.ctrl[mdu_pkg::CTL_AUTO] & full)
         | (s_q.chain & full));
   end

   // ****************************************
   // Engine link
   // ****************************************

   // The engine and buffer see the reset bit combinationally so that the abort is immediate.
   assign cif.start = take;
   assign cif.clr = soft_clr;
   assign cif.round_en = s_q.ctrl[mdu_pkg::CTL_STEP] ? step_pulse : 1'b1;
   assign cif.algo = algo;
   assign cif.block = buf_block;
   // Digest words are host-writable only while the engine is idle.
   assign cif.dg_wr = wr_acc & (kind == RG_DIGEST);
   assign cif.dg_idx = dg_idx;
   assign cif.dg_wdata = pwdata;

   // Round engine.
   mdu_round_core u_core (
      .clk_sys(clk_sys),
      .rst(rst),
      .cif(cif)
   );

   // Message buffer, double-buffered against the engine's captured copy.
   mdu_msg_buffer u_buf (
      .clk_sys(clk_sys),
      .rst(rst),
      .clr(soft_clr),
      .wr(msg_wr),
      .idx(paddr[5:2]),
      .wdata(pwdata),
      .ipad(s_q.ctrl[mdu_pkg::CTL_IPAD]),
      .opad(s_q.ctrl[mdu_pkg::CTL_OPAD]),
      .take(take),
      .algo(algo),
      .digest(cif.digest),
      .block(buf_block),
      .written(buf_written)
   );

   // ****************************************
   // Register and flag update
   // ****************************************

   // One pass computes the whole next state. Host-write clears come first and sets after them, so that
   // an event landing in the same cycle as such a clear is kept; the software reset is applied last.
   always_comb begin
      s_d = s_q;
      // The ready register answers one cycle after setup, i.e. during the access phase.
      s_d.pready = setup;
      s_d.pslverr = setup & (kind == RG_NONE);
      s_d.prdata = 32'h0000_0000;

      // Read data is captured at setup so it stands throughout the access phase.
      if (setup & ~pwrite) begin
         unique case (kind)
            RG_DIGEST: begin
               // The fifth word is returned as stored even for the 128-bit algorithms.
               s_d.prdata = s_q.ctrl[mdu_pkg::CTL_SWAP]
                  ? mdu_pkg::swap32(cif.digest[dg_idx]) : cif.digest[dg_idx];
            end
            RG_CTRL: begin
               s_d.prdata = s_q.ctrl;
            end
            RG_STATUS: begin
               s_d.prdata = 32'h0000_0000;
               s_d.prdata[mdu_pkg::ST_IRQ] = s_q.irq;
               s_d.prdata[mdu_pkg::ST_AE] = s_q.ae;
               s_d.prdata[mdu_pkg::ST_BE] = s_q.be;
               s_d.prdata[mdu_pkg::ST_DONE] = s_q.done;
            end
            RG_ID: begin
               s_d.prdata = mdu_pkg::UNIT_ID;
            end
            default: begin
               // Message words are write-only and read as zero.
               s_d.prdata = 32'h0000_0000;
            end
         endcase
      end

      // Control write: only static bits are stored; start is a pending pulse.
      if (ctrl_wr) begin
         s_d.ctrl = pwdata & mdu_pkg::CTL_STATIC_MASK;
         s_d.go = pwdata[mdu_pkg::CTL_GO];
      end

      // Status write clears everything regardless of data.
      if (wr_acc & (kind == RG_STATUS)) begin
         s_d.done = 1'b0;
         s_d.be = 1'b0;
         s_d.ae = 1'b0;
      end

      // Clearing the interrupt drops the two interrupt sources.
      if (wr_acc & (kind == RG_CLR)) begin
         s_d.done = 1'b0;
         s_d.be = 1'b0;
      end

      // Taking a block consumes the start request and marks the buffer reusable.
      if (take) begin
         s_d.go = 1'b0;
         s_d.chain = 1'b1;
         s_d.be = 1'b1;
      end

      // Pad bits clear after each single block; a full buffer carries the chain on.
      if (cif.blk_done) begin
         s_d.ctrl[mdu_pkg::CTL_IPAD] = 1'b0;
         s_d.ctrl[mdu_pkg::CTL_OPAD] = 1'b0;
         if (~full) begin
            s_d.chain = 1'b0;
            s_d.done = 1'b1;
         end
      end

      // An unmapped address raises the error flag once per transfer.
      if (setup & (kind == RG_NONE)) begin
         s_d.ae = 1'b1;
      end

      // The software reset restores everything, the bus answer excepted.
      if (soft_clr) begin
         s_d.ctrl = mdu_pkg::CTL_RESET;
         s_d.go = 1'b0;
         s_d.chain = 1'b0;
         s_d.done = 1'b0;
         s_d.be = 1'b0;
         s_d.ae = 1'b0;
      end

      // Interrupt: done, or buffer-empty with its own enable, both under the global enable.
      irq_pend = s_d.ctrl[mdu_pkg::CTL_IE] & (s_d.done
         | (s_d.be & s_d.ctrl[mdu_pkg::CTL_BIE]));
      s_d.irq = irq_pend;
   end

   // ****************************************
   // State register
   // ****************************************

   // Synchronous reset to constants only.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs come straight from flip-flops.
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign irq = s_q.irq;
endmodule

// ==== tb/mdu_host_model.sv ====
// Bus master standing in for the host processor.
`timescale 1ns/100ps
module mdu_host_model (
   // Clock.
   input wire logic clk_sys,
   // Requests.
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   // Answers.
   input wire logic [31:0] prdata,
   input wire logic pready
);
   // Idle bus from time zero.
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
   end

   // One transfer. Ready and read data are taken at the rising edge that ends the access.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// ==== tb/mdu_port_sva.sv ====
// Port checker of the message digest unit.
`timescale 1ns/100ps
module mdu_port_sva (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // Bus and interrupt.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic irq
);
   // Shadows of the global enable and the error flag, kept at completed accesses.
   logic acc;
   logic ie_q;
   logic ae_q;
   assign acc = psel && penable && pready;

   // A soft reset write clears both shadows, as it clears the unit.
   always_ff @(posedge clk_sys) begin
      if (rst || (acc && pwrite && paddr == 12'h054 && pwdata[26])) begin
         ie_q <= 1'b0;
         ae_q <= 1'b0;
      end else begin
         ie_q <= (acc && pwrite && paddr == 12'h054) ? pwdata[27] : ie_q;
         ae_q <= (acc && pslverr) || (ae_q && !(acc && pwrite && paddr == 12'h058));
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   AST_READY_NEXT: assert property (
      psel && !penable |=> pready && penable) else $error("ready missing after setup");
   AST_READY_PULSE: assert property (
      pready |=> !pready) else $error("ready held too long");
   AST_ERR_BAD: assert property (
      psel && !penable && (paddr > 12'h060 || paddr[1:0] != 2'h0) |=> pslverr)
      else $error("no error on unmapped address");
   AST_ERR_OK: assert property (
      psel && !penable && paddr <= 12'h060 && paddr[1:0] == 2'h0 |=> !pslverr)
      else $error("error on mapped address");
   AST_IRQ_GATE: assert property (
      !ie_q [*2] |-> !irq) else $error("interrupt while disabled");
   AST_SRST: assert property (
      acc && pwrite && paddr == 12'h054 && pwdata[26] |=> !irq [*3])
      else $error("interrupt survives soft reset");
   AST_ST_RSVD: assert property (
      pready && !pwrite && paddr == 12'h058 |-> prdata[27:0] == 28'h0)
      else $error("status reserved bits set");
   AST_AE: assert property (
      pready && !pwrite && paddr == 12'h058 |-> prdata[29] == ae_q)
      else $error("address error flag wrong");
   AST_CTL_UNUSED: assert property (
      pready && !pwrite && paddr == 12'h054 |-> (prdata & 32'h9487_FFFF) == 32'h0)
      else $error("unused control bits read set");
endmodule

bind mdu_message_digest_unit mdu_port_sva chk_u (
   .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .irq(irq)
);

// ==== tb/tb_top.sv ====
// Self-checking bench of the message digest unit.
`timescale 1ns/100ps
module tb_top;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, s0, da, dc;
   logic [31:0] rnd = 32'h0001_076D;
   logic [11:0] bad [3] = '{12'h064, 12'hFFC, 12'h046};
   int errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   int n [3];

   mdu_message_digest_unit dut_u (.clk_sys(clk_sys), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
   mdu_host_model host_u (.clk_sys(clk_sys), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));

   initial forever #20 clk_sys = ~clk_sys;

   // Hang guard: the whole run needs far fewer cycles than this.
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         end_sim();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {1'b0, s[31:1]} ^ (s[0] ? 32'h8020_0003 : 32'h0);
   endfunction
   function automatic logic [31:0] bsw(input logic [31:0] v);
      return {v[7:0], v[15:8], v[23:16], v[31:24]};
   endfunction

   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      host_u.xfer(1'b1, a, d, rd);
   endtask
   task automatic get(input logic [11:0] a);
      host_u.xfer(1'b0, a, 32'h0, rd);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      get(a);
      chk(rd, e);
   endtask
   // Loads one block from a seed; x lets a pad be applied by the bench instead.
   task automatic fill(input logic [31:0] s, input logic [31:0] x);
      for (int i = 0; i < 16; i++) begin
         s = lfsr(s);
         wr(12'(4 * i), s ^ x);
      end
   endtask
   task automatic wait_irq(output int c);
      c = 0;
      do begin
         @(negedge clk_sys);
         c++;
      end while (irq !== 1'b1 && c < 2000);
   endtask
   // Fresh hash from a clean unit: soft reset, fill, then the control write; returns without waiting.
   task automatic run(input logic [31:0] ctl, input logic [31:0] x);
      wr(12'h054, 32'h0400_0000);
      fill(s0, x);
      wr(12'h054, ctl);
   endtask

   initial begin
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      rd_chk(12'h054, 32'h0);
      rd_chk(12'h058, 32'h0);
      rd_chk(12'h040, mdu_pkg::DIGEST_IV[0]);
      rd_chk(12'h060, mdu_pkg::UNIT_ID);
      // Static control bits read back; unused ones read zero; start and reset bits are written as zero.
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         wr(12'h054, rnd & 32'hEBFF_FFFF);
         rd_chk(12'h054, rnd & 32'h6B78_0000);
      end
      wr(12'h054, 32'h0400_0000);
      foreach (bad[i]) begin
         wr(bad[i], rnd);
         rd_chk(12'h058, 32'h2000_0000);
         wr(12'h058, rnd);
         rd_chk(12'h058, 32'h0);
      end
      $display("test registers done");
      // Same block after a reset repeats its digest; empty buffer interrupts only if enabled.
      s0 = lfsr(rnd);
      for (int b = 0; b < 2; b++) begin
         run(32'h1800_0000 | (32'(b) << 19), 32'h0);
         repeat (4) @(negedge clk_sys);
         chk(32'(irq), 32'(b));
         repeat (120) @(negedge clk_sys);
         rd_chk(12'h058, 32'hD000_0000);
         get(12'h040);
         if (b == 0) da = rd;
         chk(rd, da);
      end
      chk(32'(da !== mdu_pkg::DIGEST_IV[0]), 32'h1);
      // A second block continues the running digest; swapped read then plain read.
      wr(12'h05C, 32'h0);
      fill(s0, 32'h0);
      wr(12'h054, 32'h3800_0000);
      repeat (120) @(negedge clk_sys);
      get(12'h040);
      dc = bsw(rd);
      chk(32'(dc !== da), 32'h1);
      wr(12'h054, 32'h0800_0000);
      rd_chk(12'h040, dc);
      $display("test chaining done");
      // Auto start, with the next block written while the first one runs.
      wr(12'h054, 32'h0400_0000);
      wr(12'h054, 32'h0810_0000);
      fill(s0, 32'h0);
      fill(s0, 32'h0);
      wait_irq(n[0]);
      rd_chk(12'h040, dc);
      // Pad applied by the unit equals the pad applied by the bench.
      for (int p = 0; p < 2; p++) begin
         wr(12'h054, 32'h0400_0000);
         wr(12'h054, 32'(1 - p) << 22);
         fill(s0, p ? mdu_pkg::PAD_INNER : 32'h0);
         wr(12'h054, 32'h1800_0000);
         repeat (120) @(negedge clk_sys);
         get(12'h040);
         if (p == 0) da = rd;
         chk(rd, da);
      end
      // Round counts of the three algorithms differ by sixteen.
      for (int k = 0; k < 3; k++) begin
         run(32'h1800_0000 | (k == 0 ? 32'h0 : 32'h0080_0000 << k), 32'h0);
         wait_irq(n[k]);
      end
      chk(32'(n[0] - n[1]), 32'h10);
      chk(32'(n[1] - n[2]), 32'h10);
      // Outer pad refills the buffer at take, so a second block follows and the bit clears.
      run(32'h1820_0000, 32'h0);
      wait_irq(n[1]);
      chk(32'(n[1] - n[0]), 32'h52);
      rd_chk(12'h054, 32'h0800_0000);
      $display("test algorithms done");
      // Single round mode stalls until each control write steps it.
      run(32'h5A00_0000, 32'h0);
      repeat (100) @(negedge clk_sys);
      rd_chk(12'h058, 32'h4000_0000);
      repeat (60) wr(12'h054, 32'h4A00_0000);
      rd_chk(12'h058, 32'hD000_0000);
      // Soft reset in mid-hash aborts it and restores the start state.
      run(32'h1800_0000, 32'h0);
      repeat (10) @(negedge clk_sys);
      wr(12'h054, 32'h0400_0000);
      repeat (150) @(negedge clk_sys);
      rd_chk(12'h058, 32'h0);
      rd_chk(12'h040, mdu_pkg::DIGEST_IV[0]);
      $display("test soft reset done");
      end_sim();
   end
endmodule
